// ===== hw/nph_core.sv
/*
  Host command handshake core: local parameter write with token join,
  remote information read, and the host buffer memory port.
  Assumes host request levels and buffer accesses are synchronous to
  sys_clk_i and that the network side follows the fetch engine protocol.
*/
`timescale 1ns/1ps
module nph_core
  import nph_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // Node switch setting
  input  wire logic [7:0]  switch_node_i,
  // Host request levels
  input  wire logic        param_write_request_i,
  input  wire logic        remote_read_request_i,
  // Host status levels
  output logic             module_ready_flag_o,
  output logic             param_write_done_o,
  output logic             param_error_flag_o,
  output logic             token_joined_flag_o,
  output logic             remote_read_done_o,
  // Host buffer memory port
  input  wire logic [15:0] bm_addr_i,
  input  wire logic        bm_wr_i,
  input  wire logic        bm_rd_i,
  input  wire logic [15:0] bm_wdata_i,
  output logic [15:0]      bm_rdata_o,
  // Network side
  output logic             net_req_o,
  output logic [7:0]       net_node_o,
  output logic             net_sel_o,
  input  wire logic        net_valid_i,
  input  wire logic [15:0] net_data_i,
  input  wire logic        net_last_i,
  input  wire logic        net_err_i
);
  import nph_pkg::*;

  logic [15:0]   param_mem [0:PARAM_WORDS-1]; // Local parameter words
  logic [15:0]   res_mem   [0:RES_WORDS-1];   // Remote data window
  logic [15:0]   target_reg;                  // Remote read target word
  logic [15:0]   pw_status_reg;               // Parameter write status
  logic [15:0]   rr_result_reg;               // Remote read result
  logic          ready_reg;                   // Module ready
  logic          pw_done_reg;                 // Write completion
  logic          pw_err_reg;                  // Parameter error
  logic          token_reg;                   // Token joined
  logic          rr_done_reg;                 // Read completion
  logic          start_reg;                   // Fetch start pulse
  logic [15:0]   rdata_reg;                   // Read data
  logic [15:0]   rdata_next;                  // Read data mux
  logic [15:0]   pw_code_next;                // Parameter check outcome
  logic          sw_ok;                       // Switch setting legal
  logic [16:0]   area1_end;                   // Bit area end
  logic [16:0]   area2_end;                   // Word area end
  logic [4:0]    res_idx;                     // Window index of host address
  nph_pw_state_t pw_state_reg;                // Parameter write sequence
  nph_rr_state_t rr_state_reg;                // Remote read sequence

  nph_fetch_if fif ();

  // ----------------------------------------------------------------
  // Module ready
  // ----------------------------------------------------------------
  // Switches are checked every cycle after release; an illegal node
  // number keeps ready low until the setting is corrected
  assign sw_ok = (switch_node_i >= NODE_MIN) && (switch_node_i <= NODE_MAX);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= sw_ok;
    end
  end

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Sums are one bit wider so an overflowing area cannot wrap to legal
  assign area1_end = {1'b0, param_mem[IDX_AREA1_START]} + {1'b0, param_mem[IDX_AREA1_SIZE]};
  assign area2_end = {1'b0, param_mem[IDX_AREA2_START]} + {1'b0, param_mem[IDX_AREA2_SIZE]};

  always_comb begin
    pw_code_next = STATUS_OK;
    if (area1_end > AREA1_WORDS) begin
      pw_code_next = ERR_AREA1;
    end else if (area2_end > AREA2_WORDS) begin
      pw_code_next = ERR_AREA2;
    end else if (param_mem[IDX_TOKEN_TIME] == RESET_WORD) begin
      pw_code_next = ERR_TOKEN_TIME;
    end
  end

  // ----------------------------------------------------------------
  // Parameter write handshake
  // ----------------------------------------------------------------
  // Parameters are judged one cycle after the request, so the area must
  // already be loaded when the request rises
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pw_state_reg  <= PW_IDLE;
      pw_done_reg   <= 1'b0;
      pw_err_reg    <= 1'b0;
      token_reg     <= 1'b0;
      pw_status_reg <= RESET_WORD;
    end else begin
      unique case (pw_state_reg)
        PW_IDLE: begin
          if (param_write_request_i && ready_reg) begin
            pw_state_reg <= PW_CHECK;
          end
        end
        PW_CHECK: begin
          pw_done_reg   <= 1'b1;
          pw_status_reg <= pw_code_next;
          pw_state_reg  <= PW_DONE;
          if (pw_code_next == STATUS_OK) begin
            pw_err_reg <= 1'b0;
            token_reg  <= 1'b1;
          end else begin
            pw_err_reg <= 1'b1;
            token_reg  <= 1'b0;   // A rejected rewrite leaves the token
          end
        end
        PW_DONE: begin
          // Done stays up until the host has seen it
          if (!param_write_request_i) begin
            pw_done_reg  <= 1'b0;
            pw_state_reg <= PW_IDLE;
          end
        end
        default: begin
          pw_state_reg <= PW_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Remote read handshake
  // ----------------------------------------------------------------
  // Node and kind come from the target word as the start pulse reaches the fetch engine, a cycle after the request is taken
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rr_state_reg  <= RR_IDLE;
      rr_done_reg   <= 1'b0;
      rr_result_reg <= RESET_WORD;
      start_reg     <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      unique case (rr_state_reg)
        RR_IDLE: begin
          if (remote_read_request_i && ready_reg) begin
            if (token_reg) begin
              start_reg    <= 1'b1;
              rr_state_reg <= RR_BUSY;
            end else begin
              // Out of the token nothing can be fetched
              rr_result_reg <= ERR_NOT_JOINED;
              rr_done_reg   <= 1'b1;
              rr_state_reg  <= RR_DONE;
            end
          end
        end
        RR_BUSY: begin
          if (fif.done) begin
            rr_result_reg <= fif.err_code;
            rr_done_reg   <= 1'b1;
            rr_state_reg  <= RR_DONE;
          end
        end
        RR_DONE: begin
          // Held until the host drops its request
          if (!remote_read_request_i) begin
            rr_done_reg  <= 1'b0;
            rr_state_reg <= RR_IDLE;
          end
        end
        default: begin
          rr_state_reg <= RR_IDLE;
        end
      endcase
    end
  end

  assign fif.start = start_reg;
  assign fif.sel   = target_reg[SEL_BIT];
  assign fif.node  = target_reg[7:0];

  // ----------------------------------------------------------------
  // Host buffer memory writes
  // ----------------------------------------------------------------
  // Status and result words are read only; writes to them are dropped
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      target_reg <= RESET_WORD;
      for (int i = 0; i < PARAM_WORDS; i++) begin
        param_mem[i] <= RESET_WORD;
      end
    end else if (bm_wr_i) begin
      if (bm_addr_i <= ADDR_PARAM_LAST) begin
        param_mem[bm_addr_i[3:0]] <= bm_wdata_i;
      end else if (bm_addr_i == ADDR_TARGET_SEL) begin
        target_reg <= bm_wdata_i;
      end
    end
  end

  // Remote window filled by the fetch engine only
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < RES_WORDS; i++) begin
        res_mem[i] <= RESET_WORD;
      end
    end else if (fif.wr_en) begin
      res_mem[fif.wr_idx] <= fif.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Host buffer memory reads
  // ----------------------------------------------------------------
  assign res_idx = RES_IDX_W'(bm_addr_i - ADDR_RES_BASE);

  // Unmapped addresses read as zero
  always_comb begin
    rdata_next = RESET_WORD;
    if (bm_addr_i <= ADDR_PARAM_LAST) begin
      rdata_next = param_mem[bm_addr_i[3:0]];
    end else if (bm_addr_i == ADDR_TARGET_SEL) begin
      rdata_next = target_reg;
    end else if (bm_addr_i == ADDR_PW_STATUS) begin
      rdata_next = pw_status_reg;
    end else if (bm_addr_i == ADDR_RR_RESULT) begin
      rdata_next = rr_result_reg;
    end else if ((bm_addr_i >= ADDR_RES_BASE) && (bm_addr_i <= ADDR_RES_LAST)) begin
      rdata_next = res_mem[res_idx];
    end
  end

  // Data holds between reads, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_reg <= RESET_WORD;
    end else if (bm_rd_i) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Fetch engine
  // ----------------------------------------------------------------
  nph_fetch u_fetch (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .fif         (fif.eng),
    .net_req_o   (net_req_o),
    .net_node_o  (net_node_o),
    .net_sel_o   (net_sel_o),
    .net_valid_i (net_valid_i),
    .net_data_i  (net_data_i),
    .net_last_i  (net_last_i),
    .net_err_i   (net_err_i)
  );

  assign module_ready_flag_o = ready_reg;
  assign param_write_done_o  = pw_done_reg;
  assign param_error_flag_o  = pw_err_reg;
  assign token_joined_flag_o = token_reg;
  assign remote_read_done_o  = rr_done_reg;
  assign bm_rdata_o          = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ready_switch: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !$past(reset_i) |-> (module_ready_flag_o == $past(sw_ok)))
    else $error("ready does not follow switch check");
  chk_write_ok_status: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ($rose(param_write_done_o) && !param_error_flag_o) |-> (pw_status_reg == STATUS_OK))
    else $error("good write with nonzero status");
  chk_write_ok_token: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ($rose(param_write_done_o) && !param_error_flag_o) |-> token_joined_flag_o)
    else $error("good write without token join");
  chk_write_bad_code: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ($rose(param_write_done_o) && param_error_flag_o) |-> (pw_status_reg != STATUS_OK))
    else $error("failed write with zero status");
  chk_write_timing: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (pw_state_reg == PW_IDLE && param_write_request_i && module_ready_flag_o)
      |-> ##2 param_write_done_o)
    else $error("write completion not two cycles after request");
  chk_write_done_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (param_write_done_o && !param_write_request_i) |=> !param_write_done_o)
    else $error("write done kept after request dropped");
  chk_read_done_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (remote_read_done_o && !remote_read_request_i) |=> !remote_read_done_o)
    else $error("read done kept after request dropped");
  chk_read_result: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (rr_state_reg == RR_BUSY && fif.done) |=> remote_read_done_o
      && (rr_result_reg == $past(fif.err_code)))
    else $error("read result not taken from fetch outcome");
  chk_read_held: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (remote_read_done_o && remote_read_request_i) |=> remote_read_done_o)
    else $error("read done dropped while request high");
  cov_write_ok: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(param_write_done_o) && !param_error_flag_o);
  cov_write_bad: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(param_write_done_o) && param_error_flag_o);
  cov_read_ok: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(remote_read_done_o) && (rr_result_reg == STATUS_OK));

endmodule

// ===== hw/nph_pkg.sv
/*
  Constants, encodings and state types for the network parameter host
  handshake block.
  Assumes a 16-bit word-addressed buffer memory port from the host CPU.
*/
package nph_pkg;

  // ----------------------------------------------------------------
  // Buffer memory map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PARAM_LAST = 16'h000f; // Local parameter area end
  localparam logic [15:0] ADDR_TARGET_SEL = 16'h0983; // Remote read target word
  localparam logic [15:0] ADDR_PW_STATUS  = 16'h09d2; // Parameter write status
  localparam logic [15:0] ADDR_RR_RESULT  = 16'h09d3; // Remote read result
  localparam logic [15:0] ADDR_RES_BASE   = 16'h1200; // Remote data window start
  localparam logic [15:0] ADDR_RES_LAST   = 16'h121b; // Remote data window end

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          PARAM_WORDS     = 16;       // Stored local words
  localparam int          RES_WORDS       = 28;       // Remote window words
  localparam int          RES_IDX_W       = 5;        // Remote window index width
  localparam logic [4:0]  RES_LAST_IDX    = 5'h1b;    // Last remote window index
  localparam logic [3:0]  IDX_AREA1_START = 4'h8;     // Bit area start
  localparam logic [3:0]  IDX_AREA1_SIZE  = 4'h9;     // Bit area size
  localparam logic [3:0]  IDX_AREA2_START = 4'ha;     // Word area start
  localparam logic [3:0]  IDX_AREA2_SIZE  = 4'hb;     // Word area size
  localparam logic [3:0]  IDX_TOKEN_TIME  = 4'hc;     // Token watch timeout
  localparam int          SEL_BIT         = 15;       // Read kind select bit
  localparam logic [16:0] AREA1_WORDS     = 17'h00200; // Bit area capacity
  localparam logic [16:0] AREA2_WORDS     = 17'h02000; // Word area capacity
  localparam logic [7:0]  NODE_MIN        = 8'h01;    // Lowest legal node
  localparam logic [7:0]  NODE_MAX        = 8'hfe;    // Highest legal node

  // ----------------------------------------------------------------
  // Reset values and result codes
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_WORD      = 16'h0000; // Cleared word
  localparam logic [15:0] STATUS_OK       = 16'h0000; // Success code
  localparam logic [15:0] ERR_AREA1       = 16'h0001; // Bit area overflow
  localparam logic [15:0] ERR_AREA2       = 16'h0002; // Word area overflow
  localparam logic [15:0] ERR_TOKEN_TIME  = 16'h0003; // Zero token timeout
  localparam logic [15:0] ERR_NOT_JOINED  = 16'h0010; // Read while not in token
  localparam logic [15:0] ERR_REMOTE      = 16'h0011; // Remote node failure

  // ----------------------------------------------------------------
  // State encodings (one bit changes per step from idle up to done)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PW_IDLE  = 2'b00,
    PW_CHECK = 2'b01,
    PW_DONE  = 2'b11
  } nph_pw_state_t;

  typedef enum logic [1:0] {
    RR_IDLE = 2'b00,
    RR_BUSY = 2'b01,
    RR_DONE = 2'b11
  } nph_rr_state_t;

  typedef enum logic {
    FE_IDLE = 1'b0,
    FE_WAIT = 1'b1
  } nph_fe_state_t;

endpackage

// ===== hw/nph_fetch_if.sv
/*
  Carrier between the handshake core and the remote fetch engine.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface nph_fetch_if;
  logic        start;     // One-cycle start of a fetch
  logic        sel;       // 0 parameters, 1 join information
  logic [7:0]  node;      // Target node number
  logic        wr_en;     // Result word strobe
  logic [4:0]  wr_idx;    // Result word index
  logic [15:0] wr_data;   // Result word
  logic        done;      // One-cycle fetch end
  logic [15:0] err_code;  // Fetch outcome, zero on success

  modport ctl (output start, sel, node, input wr_en, wr_idx, wr_data, done, err_code);
  modport eng (input start, sel, node, output wr_en, wr_idx, wr_data, done, err_code);
endinterface

// ===== hw/nph_fetch.sv
/*
  Remote fetch engine: asks the network side for a node's information
  and streams the returned words into the result window.
  Assumes the network side answers each request with valid words and
  ends with a last or error strobe.
*/
`timescale 1ns/1ps
module nph_fetch
  import nph_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // Core side
  nph_fetch_if.eng         fif,
  // Network side
  output logic             net_req_o,
  output logic [7:0]       net_node_o,
  output logic             net_sel_o,
  input  wire logic        net_valid_i,
  input  wire logic [15:0] net_data_i,
  input  wire logic        net_last_i,
  input  wire logic        net_err_i
);
  import nph_pkg::*;

  nph_fe_state_t state_reg;     // Engine state
  logic [4:0]    cnt_reg;       // Next result index
  logic          wr_en_reg;     // Registered strobe
  logic [4:0]    wr_idx_reg;    // Registered index
  logic [15:0]   wr_data_reg;   // Registered word
  logic          done_reg;      // Registered end pulse
  logic [15:0]   err_reg;       // Registered outcome
  logic          req_reg;       // Network request level
  logic [7:0]    node_reg;      // Captured node
  logic          sel_reg;       // Captured select

  // ----------------------------------------------------------------
  // Request sequencing
  // ----------------------------------------------------------------
  // Request level stays up until the network ends the frame
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= FE_IDLE;
      req_reg   <= 1'b0;
      node_reg  <= 8'h00;
      sel_reg   <= 1'b0;
      done_reg  <= 1'b0;
      err_reg   <= STATUS_OK;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        FE_IDLE: begin
          if (fif.start) begin
            req_reg   <= 1'b1;
            node_reg  <= fif.node;
            sel_reg   <= fif.sel;
            state_reg <= FE_WAIT;
          end
        end
        FE_WAIT: begin
          if (net_last_i || net_err_i) begin
            req_reg   <= 1'b0;
            done_reg  <= 1'b1;
            err_reg   <= net_err_i ? ERR_REMOTE : STATUS_OK;
            state_reg <= FE_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result streaming
  // ----------------------------------------------------------------
  // Words past the window end are dropped, so nothing outside it is hit
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_reg     <= 5'h00;
      wr_en_reg   <= 1'b0;
      wr_idx_reg  <= 5'h00;
      wr_data_reg <= RESET_WORD;
    end else begin
      wr_en_reg <= 1'b0;
      if (state_reg == FE_IDLE) begin
        cnt_reg <= 5'h00;
      end else if (net_valid_i && (cnt_reg <= RES_LAST_IDX)) begin
        wr_en_reg   <= 1'b1;
        wr_idx_reg  <= cnt_reg;
        wr_data_reg <= net_data_i;
        cnt_reg     <= 5'(cnt_reg + 5'h01);
      end
    end
  end

  assign fif.wr_en    = wr_en_reg;
  assign fif.wr_idx   = wr_idx_reg;
  assign fif.wr_data  = wr_data_reg;
  assign fif.done     = done_reg;
  assign fif.err_code = err_reg;
  assign net_req_o    = req_reg;
  assign net_node_o   = node_reg;
  assign net_sel_o    = sel_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_window_bound: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    wr_en_reg |-> (wr_idx_reg <= RES_LAST_IDX))
    else $error("result write outside window");
  chk_select_capture: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == FE_IDLE && fif.start) |=> (net_sel_o == $past(fif.sel)) && net_req_o)
    else $error("read kind not taken from start");
  cov_full_window: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    wr_en_reg && (wr_idx_reg == RES_LAST_IDX));

endmodule

// ===== verif/nph_net_model.sv
/*
  Network side model: answers each fetch request with 28 words or a failure.
  Assumes the core samples on the rising edge of sys_clk_i.
*/
`timescale 1ns/1ps
module nph_net_model (
  input  wire logic       sys_clk_i,
  input  wire logic       net_req_i,
  input  wire logic [7:0] net_node_i,
  input  wire logic       net_sel_i,
  input  wire logic       fail_i,
  output logic            net_valid_o,
  output logic [15:0]     net_data_o,
  output logic            net_last_o,
  output logic            net_err_o
);
  logic [5:0] cnt_reg;  // Words sent in this frame
  initial begin
    {net_valid_o, net_last_o, net_err_o, cnt_reg} = '0;
    net_data_o = 16'h0000;
  end
  // Idle data toggles so a stale word never looks valid
  always @(negedge sys_clk_i) begin
    net_valid_o <= 1'b0;
    net_last_o  <= 1'b0;
    net_err_o   <= 1'b0;
    net_data_o  <= ~net_data_o;
    if (!net_req_i) begin
      cnt_reg <= 6'h00;
    end else if (fail_i && cnt_reg == 6'h00) begin
      net_err_o <= 1'b1;
      cnt_reg   <= 6'h3f;
    end else if (cnt_reg < 6'h1c) begin
      net_valid_o <= 1'b1;
      net_data_o  <= {net_node_i, net_sel_i, 2'b00, cnt_reg[4:0]};
      net_last_o  <= (cnt_reg == 6'h1b);
      cnt_reg     <= cnt_reg + 6'h01;
    end
  end
endmodule

// ===== verif/nph_core_tb_top.sv
/*
  Bench for the handshake core: host requests and buffer accesses.
  Assumes the network side model answers every fetch.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module nph_core_tb_top;
  import nph_pkg::*;
  logic clk = 0, rst = 1, pwr = 0, rrr = 0, wr = 0, rd = 0, fail = 0;
  logic rdy, pwd, perr, tok, rrd, nreq, nsel, nv, nl, ne;
  logic [7:0]  sw = 8'h00, nnode;
  logic [15:0] addr = 16'h0000, wd = 16'h0000, rdata, nd;
  int n_fail = 0, n_tests = 0;
  always #50 clk = ~clk;
  nph_core dut_u (.sys_clk_i(clk), .reset_i(rst), .switch_node_i(sw),
    .param_write_request_i(pwr), .remote_read_request_i(rrr),
    .module_ready_flag_o(rdy), .param_write_done_o(pwd), .param_error_flag_o(perr),
    .token_joined_flag_o(tok), .remote_read_done_o(rrd), .bm_addr_i(addr),
    .bm_wr_i(wr), .bm_rd_i(rd), .bm_wdata_i(wd), .bm_rdata_o(rdata),
    .net_req_o(nreq), .net_node_o(nnode), .net_sel_o(nsel), .net_valid_i(nv),
    .net_data_i(nd), .net_last_i(nl), .net_err_i(ne));
  nph_net_model net_u (.sys_clk_i(clk), .net_req_i(nreq), .net_node_i(nnode),
    .net_sel_i(nsel), .fail_i(fail), .net_valid_o(nv), .net_data_o(nd),
    .net_last_o(nl), .net_err_o(ne));
  task automatic wrw(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  // Request, wait for done, then drop and see done clear
  task automatic hs(input bit w);
    int i;
    @(negedge clk);
    if (w) pwr = 1;
    else rrr = 1;
    for (i = 0; i < 200 && (w ? pwd : rrd) !== 1'b1; i++) @(negedge clk);
    `CHK(w ? pwd : rrd, 1'b1)
    if (w) pwr = 0;
    else rrr = 0;
    for (i = 0; i < 5 && (w ? pwd : rrd) !== 1'b0; i++) @(negedge clk);
    `CHK(w ? pwd : rrd, 1'b0)
  endtask
  task automatic wcase(input logic [15:0] a, input logic [15:0] d, input logic [15:0] e);
    wrw(a, d);
    hs(1);
    `CHK({perr, tok}, {e != 16'h0000, e == 16'h0000})
    chk(ADDR_PW_STATUS, e);
  endtask
  task automatic complete_run();
    $display("counts: tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog of 20000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    repeat (3) @(negedge clk);
    `CHK(rdy, 1'b0)
    sw = 8'h03;
    repeat (3) @(negedge clk);
    `CHK(rdy, 1'b1)
    wrw(ADDR_RR_RESULT, 16'hffff);
    chk(ADDR_RR_RESULT, RESET_WORD);
    chk(16'h0500, RESET_WORD);
    wrw(ADDR_TARGET_SEL, 16'h0005);
    hs(0);
    chk(ADDR_RR_RESULT, ERR_NOT_JOINED);
    $display("test ready and refusal done");
    // Word area set up first, the bit area that guards it last
    wrw(16'h000a, 16'h1fff);
    wrw(16'h000b, 16'h0002);
    wrw(16'h0008, 16'h01ff);
    wcase(16'h0009, 16'h0002, ERR_AREA1);
    wcase(16'h0009, 16'h0001, ERR_AREA2);
    wcase(16'h000b, 16'h0001, ERR_TOKEN_TIME);
    wcase(16'h000c, 16'h0032, STATUS_OK);
    $display("test parameter write done");
    `CHK(tok, 1'b1)
    hs(0);
    chk(ADDR_RES_BASE, 16'h0500);
    chk(ADDR_RES_LAST, 16'h051b);
    chk(ADDR_RR_RESULT, STATUS_OK);
    wrw(ADDR_TARGET_SEL, 16'h8007);
    hs(0);
    chk(ADDR_RES_BASE, 16'h0780);
    fail = 1;
    hs(0);
    fail = 0;
    chk(ADDR_RR_RESULT, ERR_REMOTE);
    $display("test remote read done");
    complete_run();
  end
endmodule
